/* rtl/flash_adc_pkg.sv */
package flash_adc_pkg;
  localparam int unsigned MAIN_LINES     = 7;
  localparam int unsigned LINES          = 8;
  localparam int unsigned CODE_W         = 3;
  localparam int unsigned WORD_W         = 4;
  localparam int unsigned OVR_POS        = 3;
  localparam logic [3:0]  WORD_RESET     = 4'h0;
  localparam logic [3:0]  WORD_OVERRANGE = 4'h8;
  localparam logic [3:0]  WORD_TOP_MAIN  = 4'h7;
  localparam int unsigned CODE_STATES    = 8;
  localparam int unsigned TRANSITIONS    = 7;
  typedef enum logic [0:0]
  {
    PH_COMPARE = 1'b0,
    PH_LATCHED = 1'b1
  } phase_t;
endpackage

/* rtl/therm_if.sv */
interface therm_if;
  import flash_adc_pkg::*;
  logic [LINES-1:0]  lines;
  logic [WORD_W-1:0] word;
  logic              bubble;
  modport enc
  (
    input  lines,
    output word,
    output bubble
  );
  modport user
  (
    output lines,
    input  word,
    input  bubble
  );
endinterface

/* rtl/therm_encoder.sv */
module therm_encoder
  import flash_adc_pkg::*;
(
  therm_if.enc t
);
  logic [LINES:1] a;
  always_comb
  begin
    a = t.lines;
  end
  always_comb
  begin
    t.word = WORD_RESET;
    if (a[8])
    begin
      t.word = WORD_OVERRANGE; // R04
    end
    else
    begin
      t.word[2] = a[4]; // R02
      t.word[1] = a[6] | (a[2] & ~a[4]); // R02
      t.word[0] = a[7] | (a[5] & ~a[6]) | (a[3] & ~a[4]) | (a[1] & ~a[2]); // R02
    end
  end
  // a legal code never has a high line above a low one
  always_comb
  begin
    t.bubble = |(a[LINES:2] & ~a[LINES-1:1]); // R01
  end
endmodule

/* rtl/flash_adc_thermometer_decoder.sv */
// Functional notes
// R01 - inputs arrive as thermometer code, one more line high per step
// R02 - binary bits formed by fixed gate equations from comparator lines
// R03 - bit 1 is the msb, bit 3 the lsb of the three-bit result
// R04 - eighth comparator is overrange; all eight high gives word 1000
// R05 - all low gives 0000, each extra line adds one, up to 0111
// R06 - latch enable chooses compare or latched; latched output stays frozen
// R07 - n bits give 2^n codes separated by 2^n-1 transitions
// R08 - outside logic may join converters with overrange for more bits
// R09 - word and overrange registered on the edge ending compare phase
module flash_adc_thermometer_decoder
  import flash_adc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [LINES-1:0]  comp_lines,
  input  wire logic              latch_enable,
  output logic      [LINES-1:0]  held_lines,
  output logic                   latched,
  output logic      [CODE_W-1:0] code_bits,
  output logic                   overrange,
  output logic                   code_error,
  output logic                   result_valid
);
  // the gate equations only serve three code bits; line, state and word sizes that disagree with CODE_W are refused
  if (LINES != (1 << CODE_W) || MAIN_LINES != LINES - 1)
  begin : g_bad_lines
    $error("line count does not match code width"); // R07
  end
  if (CODE_STATES != (1 << CODE_W) || TRANSITIONS != CODE_STATES - 1)
  begin : g_bad_states
    $error("code states and transitions disagree"); // R07
  end
  if (WORD_W != CODE_W + 1 || OVR_POS != CODE_W)
  begin : g_bad_word
    $error("word must be the code plus one overrange bit"); // R04
  end
  //////////////////////////////////////////////////////////////////////////////
  phase_t            phase_q;
  phase_t            phase_d;
  logic [LINES-1:0]  hold_q;
  logic [LINES-1:0]  hold_d;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;
  logic              err_q;
  logic              err_d;
  logic              valid_q;
  logic              valid_d;
  logic              end_compare;
  therm_if           t ();
  // comparator hold: tracks while comparing, frozen while latched
  always_comb
  begin
    phase_d = latch_enable ? PH_LATCHED : PH_COMPARE;
    hold_d  = hold_q;
    unique case (phase_q)
      PH_COMPARE: hold_d = comp_lines; // R06
      PH_LATCHED: hold_d = hold_q; // R06
    endcase
  end
  always_comb
  begin
    end_compare = (phase_q == PH_COMPARE) && latch_enable;
  end
  //////////////////////////////////////////////////////////////////////////////
  // decode the live lines so the captured word matches the frozen lines
  always_comb
  begin
    t.lines = comp_lines; // R01
  end
  therm_encoder u_enc
  (
    .t (t)
  );
  always_comb
  begin
    word_d  = word_q;
    err_d   = err_q;
    valid_d = valid_q;
    if (end_compare)
    begin
      word_d  = t.word; // R09
      err_d   = t.bubble;
      valid_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      phase_q <= PH_COMPARE;
      hold_q  <= '0;
      word_q  <= WORD_RESET;
      err_q   <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      hold_q  <= hold_d;
      word_q  <= word_d;
      err_q   <= err_d;
      valid_q <= valid_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // overrange kept as a separate pin so two decoders can be cascaded
  always_comb
  begin
    held_lines   = hold_q;
    latched      = (phase_q == PH_LATCHED);
    code_bits    = word_q[CODE_W-1:0]; // R03
    overrange    = word_q[OVR_POS]; // R04 R08
    code_error   = err_q;
    result_valid = valid_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  // helpers used only by the checks below
  function automatic logic [WORD_W-1:0] ones_count(input logic [LINES-1:0] v);
    logic [WORD_W-1:0] n;
    n = '0;
    for (int i = 0; i < LINES; i++)
      n = n + WORD_W'(v[i]);
    return n;
  endfunction
  function automatic logic is_therm(input logic [LINES-1:0] v);
    return ((v + LINES'(1)) & v) == '0;
  endfunction

  // sequences name the steps of the latch-enable handshake
  sequence s_compare_end;
    (phase_q == PH_COMPARE) && latch_enable;
  endsequence

  sequence s_stay_latched;
    (phase_q == PH_LATCHED) && latch_enable;
  endsequence

  sequence s_release;
    (phase_q == PH_LATCHED) && !latch_enable;
  endsequence

  sequence s_compare_idle;
    (phase_q == PH_COMPARE) && !latch_enable;
  endsequence

  a_capture_count: assert property (@(posedge core_clk) disable iff (reset) // R05
    (s_compare_end and is_therm(comp_lines)) |=>
    {overrange, code_bits} == $past(ones_count(comp_lines)))
    else $error("captured word is not the count of high lines");

  a_overrange_word: assert property (@(posedge core_clk) disable iff (reset) // R04
    (s_compare_end and (comp_lines == '1)) |=>
    {overrange, code_bits} == WORD_OVERRANGE)
    else $error("all lines high did not give the overrange word");

  a_overrange_low: assert property (@(posedge core_clk) disable iff (reset) // R04
    (s_compare_end and !comp_lines[7]) |=> !overrange)
    else $error("overrange set without the eighth comparator");

  a_top_main_word: assert property (@(posedge core_clk) disable iff (reset) // R05
    (s_compare_end and (comp_lines == 8'h7F)) |=>
    {overrange, code_bits} == WORD_TOP_MAIN)
    else $error("seven lines high did not give the top code");

  a_msb_is_line4: assert property (@(posedge core_clk) disable iff (reset) // R03
    (s_compare_end and !comp_lines[7]) |=>
    code_bits[2] == $past(comp_lines[3]))
    else $error("msb does not follow comparator four");

  a_mid_bit_eq: assert property (@(posedge core_clk) disable iff (reset) // R02
    (s_compare_end and !comp_lines[7]) |=>
    code_bits[1] == $past(comp_lines[5] | (comp_lines[1] & ~comp_lines[3])))
    else $error("middle bit equation broken");

  a_lsb_bit_eq: assert property (@(posedge core_clk) disable iff (reset) // R02
    (s_compare_end and !comp_lines[7]) |=>
    code_bits[0] == $past(comp_lines[6] | (comp_lines[4] & ~comp_lines[5]) |
    (comp_lines[2] & ~comp_lines[3]) | (comp_lines[0] & ~comp_lines[1])))
    else $error("least significant bit equation broken");

  a_hold_frozen: assert property (@(posedge core_clk) disable iff (reset) // R06
    s_stay_latched ##1 s_stay_latched |-> $stable(held_lines))
    else $error("held lines moved while latched");

  a_hold_tracks: assert property (@(posedge core_clk) disable iff (reset) // R06
    phase_q == PH_COMPARE |=> held_lines == $past(comp_lines))
    else $error("held lines did not track in compare mode");

  a_latch_holds: assert property (@(posedge core_clk) disable iff (reset) // R06
    s_stay_latched |=> latched)
    else $error("latched phase left while latch enable stayed high");

  a_leave_latched: assert property (@(posedge core_clk) disable iff (reset) // R06
    s_release |=> !latched && $stable(held_lines))
    else $error("release did not return to compare with lines frozen");

  a_recapture_step: assert property (@(posedge core_clk) disable iff (reset) // R06
    s_release ##1 s_compare_end |=>
    latched && held_lines == $past(comp_lines))
    else $error("new comparison after release was not captured");

  a_compare_open: assert property (@(posedge core_clk) disable iff (reset) // R06
    s_compare_idle |=> !latched && $stable(result_valid))
    else $error("compare phase closed without latch enable");

  a_enter_latched: assert property (@(posedge core_clk) disable iff (reset) // R09
    s_compare_end |=> latched && result_valid)
    else $error("end of compare did not latch a valid result");

  a_word_steady: assert property (@(posedge core_clk) disable iff (reset) // R09
    !end_compare |=> $stable({overrange, code_bits}) && $stable(result_valid))
    else $error("result changed outside the end of compare");

  a_err_steady: assert property (@(posedge core_clk) disable iff (reset) // R09
    !end_compare |=> $stable(code_error))
    else $error("error flag changed outside the end of compare");

  a_valid_sticky: assert property (@(posedge core_clk) disable iff (reset) // R09
    result_valid |=> result_valid)
    else $error("valid flag dropped without reset");

  a_bubble_flag: assert property (@(posedge core_clk) disable iff (reset) // R01
    s_compare_end |=> code_error == !$past(is_therm(comp_lines)))
    else $error("bubble flag disagrees with input pattern");
endmodule

/* testbench/comparator_bank_model.sv */
module comparator_bank_model
  import flash_adc_pkg::*;
(
  input  wire logic [3:0]       level,
  input  wire logic             bubble_on,
  output logic      [LINES-1:0] lines
);
  // one more line per step; bubble inverts comparator 2 only on demand
  assign lines = ((8'h01 << level) - 8'h01) ^ (bubble_on ? 8'h02 : 8'h00);
endmodule

/* testbench/flash_adc_thermometer_decoder_tb_top.sv */
module flash_adc_thermometer_decoder_tb_top
  import flash_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk;
  logic              reset;
  logic              latch_enable;
  logic              bubble_on;
  logic [3:0]        level;
  logic [LINES-1:0]  comp_lines;
  logic [LINES-1:0]  held_lines;
  logic              latched;
  logic [CODE_W-1:0] code_bits;
  logic              overrange;
  logic              code_error;
  logic              result_valid;
  int                bad_count;
  int                checked;
  ////////////////////////////////////////
  comparator_bank_model bank (.level(level), .bubble_on(bubble_on), .lines(comp_lines));
  flash_adc_thermometer_decoder DUT (.core_clk(core_clk), .reset(reset),
    .comp_lines(comp_lines), .latch_enable(latch_enable), .held_lines(held_lines),
    .latched(latched), .code_bits(code_bits), .overrange(overrange),
    .code_error(code_error), .result_valid(result_valid));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // low for one edge then high: the next edge ends the compare phase
  task automatic capture(input logic [3:0] lvl, input logic bub);
    @(posedge core_clk);
    latch_enable <= 1'b0;
    level <= lvl;
    bubble_on <= bub;
    @(posedge core_clk);
    latch_enable <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // all nine patterns, every code once
  task automatic sweep_levels;
    for (int l = 0; l <= 8; l++)
    begin
      capture(4'(l), 1'b0);
      check_val({4'h0, overrange, code_bits}, (l == 8) ? 8'h08 : 8'(l));
      check_val(held_lines, 8'((9'h001 << l) - 9'h001));
      check_val({5'h0, code_error, latched, result_valid}, 8'h03);
    end
  endtask
  task automatic freeze_hold;
    capture(4'h3, 1'b0);
    @(posedge core_clk);
    level <= 4'h6;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check_val(held_lines, 8'h07);
    check_val({3'h0, overrange, code_bits, latched}, 8'h07);
    @(posedge core_clk);
    latch_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check_val(held_lines, 8'h3F);
    check_val({3'h0, overrange, code_bits, latched}, 8'h06);
  endtask
  // broken thermometer still goes through the gate equations
  task automatic bubble_input;
    capture(4'h3, 1'b1);
    check_val({4'h0, overrange, code_bits}, 8'h01);
    check_val({7'h00, code_error}, 8'h01);
  endtask
  ////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    latch_enable = 1'b0;
    level = 4'h0;
    bubble_on = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check_val({3'h0, result_valid, latched, code_bits}, 8'h00);
    sweep_levels();
    freeze_hold();
    bubble_input();
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check_val({3'h0, result_valid, overrange, code_bits}, 8'h00);
    conclude();
  end
endmodule
